/* File: tb/ppv_link_properties.sv */
// link pin assertions for the program/verify port
`timescale 1ns/1ps
module ppv_link_properties #(
  parameter int WRITE_CYC = 8
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // link pins
  input wire logic [3:0] mode_select_pins,
  input wire logic step_clock_in,
  input wire logic step_clock_complement,
  input wire logic prog_supply_ok,
  input wire logic host_oe,
  input wire logic dev_oe
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  logic [15:0] wr_run;
  logic wr_now;
  logic inh;
  // mode helpers, inhibit is H,x,H,H
  assign wr_now = prog_supply_ok && mode_select_pins == 4'hE;
  assign inh = mode_select_pins[0] && mode_select_pins[3:2] == 2'h3;
  // write length so far; cleared on reset so a cut pulse is not judged
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wr_run <= 16'h0;
    end else begin
      wr_run <= wr_now ? wr_run + 16'h1 : 16'h0;
    end
  end
  sequence seq_verify_held;
    (prog_supply_ok && mode_select_pins == 4'hC) [*2];
  endsequence
  sequence seq_active_entry;
    $changed(mode_select_pins) && (mode_select_pins inside {4'h5, 4'hE, 4'hC});
  endsequence
  chk_clock_inverse: assert property (step_clock_complement == !step_clock_in)
    else $error("step complement is not the inverse");
  chk_via_inhibit: assert property (seq_active_entry |-> $past(inh))
    else $error("active mode entered without inhibit");
  chk_supply_on: assert property ($rose(prog_supply_ok) |-> mode_select_pins == 4'h5)
    else $error("supply raised outside clear mode");
  chk_supply_off: assert property ($fell(prog_supply_ok) |-> $past(mode_select_pins) == 4'h5)
    else $error("supply dropped outside clear mode");
  chk_verify_drives: assert property (seq_verify_held |-> dev_oe)
    else $error("device silent in verify");
  chk_oe_cause: assert property (dev_oe |-> $past(prog_supply_ok && mode_select_pins == 4'hC))
    else $error("device drives outside verify");
  chk_no_fight: assert property (!(dev_oe && host_oe))
    else $error("both ends drive the nibbles");
  chk_step_inhibit: assert property ($changed(step_clock_in) |-> inh)
    else $error("step clock moved outside inhibit");
  chk_write_length: assert property (wr_run != 16'h0 && !wr_now |-> wr_run % WRITE_CYC == 0)
    else $error("write pulse not a whole number of periods");
  cover property (seq_verify_held);
endmodule // ppv_link_properties

/* File: tb/prom_program_verify_port_bench.sv */
// bench: host and device joined, plus a second device driven pin by pin
`timescale 1ns/1ps
`include "ppv_consts.svh"
module prom_program_verify_port_bench import ppv_pkg::*;;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic start_i = 1'b0;
  logic [13:0] last_addr_i = 14'h0;
  logic byte_valid_i = 1'b0;
  logic [7:0] byte_i = 8'h00;
  logic byte_ready_o, busy_o, done_o, fail_o, wrote_o, wrote2, pstep, pdoe;
  logic [13:0] addr_o, addr2, paddr;
  logic [3:0] pm;
  logic [7:0] pdata;
  logic [7:0] exp_q[$];
  ppv_op_t op_o, op2;
  int failures = 0;
  int cmp_count = 0;
  int rises, reads, refused, base, writes;
  ppv_link_if lk();
  ppv_link_if lk2();
  ppv_device u_ppv_device (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .link(lk.device),
    .addr_o(addr_o), .op_o(op_o), .wrote_o(wrote_o));
  ppv_device u_ppv_device_2 (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
    .link(lk2.device), .addr_o(addr2), .op_o(op2), .wrote_o(wrote2));
  ppv_host #(.WRITE_CYC(8), .MAX_TRIES(25)) u_ppv_host (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .ce_i(ce_i), .link(lk.host), .start_i(start_i), .last_addr_i(last_addr_i),
    .byte_valid_i(byte_valid_i), .byte_ready_o(byte_ready_o), .byte_i(byte_i),
    .busy_o(busy_o), .done_o(done_o), .fail_o(fail_o));
  ppv_link_properties #(.WRITE_CYC(8)) u_ppv_link_properties (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .mode_select_pins(lk.mode_select_pins), .step_clock_in(lk.step_clock_in),
    .step_clock_complement(lk.step_clock_complement), .prog_supply_ok(lk.prog_supply_ok),
    .host_oe(lk.host_oe), .dev_oe(lk.dev_oe));
  // 40 MHz clock
  always #12.5 clk_sys_i = ~clk_sys_i;
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // inputs move a fixed 2 ns after the edge so no race with sampling
  task automatic tick(int n);
    repeat (n) @(posedge clk_sys_i);
    #2;
  endtask
  function automatic ppv_op_t exp_op(logic [3:0] m);
    if (m == 4'h5) return PPV_OP_CLEAR;
    if (m == 4'hE) return PPV_OP_WRITE;
    if (m == 4'hC) return PPV_OP_VERIFY;
    if (m[0] && m[3:2] == 2'h3) return PPV_OP_INHIBIT;
    return PPV_OP_IDLE;
  endfunction
  // wire watcher: byte per location judged on the nibbles, step edges counted
  always @(posedge clk_sys_i) begin
    if (!rst_i) begin
      if (lk.step_clock_in === 1'b1 && pstep === 1'b0) rises++;
      if (pm == 4'hE && lk.mode_select_pins != 4'hE) begin
        writes++;
        check("write byte", 16'(pdata), 16'(exp_q[base + rises / 4]));
      end
      if (pdoe === 1'b1 && lk.dev_oe === 1'b0) begin
        reads++;
        check("verify byte", 16'(pdata), 16'(exp_q[base + rises / 4]));
      end
      if (addr_o != paddr && addr_o != 14'h0) begin
        check("addr step", 16'(addr_o), 16'(paddr + 14'h1));
      end
    end
    pstep = lk.step_clock_in;
    pdoe = lk.dev_oe;
    pm = lk.mode_select_pins;
    pdata = {lk.data_high_nibble, lk.data_low_nibble};
    paddr = addr_o;
  end
  task automatic run_prog(int n);
    int t;
    rises = 0;
    reads = 0;
    refused = 0;
    writes = 0;
    base = exp_q.size();
    for (t = 0; t < n; t++) exp_q.push_back(8'hA5 + 8'(t * 59));
    last_addr_i = 14'(n - 1);
    start_i = 1'b1;
    tick(1);
    start_i = 1'b0;
    // fill faster than the host drains, so a run of more than 8 bytes makes the fifo refuse
    for (t = 0; t < n; t++) begin
      byte_i = exp_q[base + t];
      byte_valid_i = 1'b1;
      while (byte_ready_o !== 1'b1) begin
        refused++;
        tick(1);
      end
      tick(1);
    end
    byte_valid_i = 1'b0;
    t = 0;
    while (done_o !== 1'b1 && t < 20000) begin
      tick(1);
      t++;
    end
    check("done", 16'(done_o), 16'h1);
    check("fail", 16'(fail_o), 16'h0);
    check("pulses", 16'(rises), 16'(4 * n));
    check("verifies", 16'(reads), 16'(n));
    check("extra writes", 16'(writes), 16'(2 * n));
    tick(2);
    check("addr home", 16'(addr_o), 16'h0);
    $display("program run of %0d bytes ended", n);
  endtask
  task automatic drive(logic [3:0] m, logic s, logic [7:0] d, int n);
    lk2.mode_select_pins = m;
    lk2.prog_supply_ok = s;
    lk2.host_oe = (m != 4'hC);
    {lk2.hi_host, lk2.lo_host} = d;
    tick(n);
  endtask
  task automatic pulse(int k);
    repeat (k) begin
      lk2.step_clock_in = 1'b1;
      lk2.step_clock_complement = 1'b0;
      tick(2);
      lk2.step_clock_in = 1'b0;
      lk2.step_clock_complement = 1'b1;
      tick(2);
    end
  endtask
  // hang guard, about a hundred times the expected run
  initial begin
    #1500000;
    failures++;
    $display("watchdog expired");
    test_done();
  end
  initial begin
    lk2.mode_select_pins = 4'hF;
    lk2.step_clock_in = 1'b0;
    lk2.step_clock_complement = 1'b1;
    lk2.prog_supply_ok = 1'b0;
    {lk2.hi_host, lk2.lo_host} = 8'h00;
    lk2.host_oe = 1'b0;
    repeat (12) @(posedge clk_sys_i);
    #2;
    rst_i = 1'b0;
    tick(1);
    run_prog(10);
    check("fifo full", 16'(refused != 0), 16'h1);
    run_prog(1);
    drive(4'h5, 1'b0, 8'h3C, 3);
    check("op no supply", 16'(op2), 16'(PPV_OP_IDLE));
    drive(4'hE, 1'b0, 8'h3C, 3);
    check("write no supply", 16'(wrote2), 16'h0);
    drive(4'h5, 1'b1, 8'h3C, 3);
    check("addr clear", 16'(addr2), 16'h0);
    drive(4'hD, 1'b1, 8'h3C, 2);
    drive(4'hE, 1'b1, 8'h3C, 3);
    check("write op", 16'(wrote2), 16'h1);
    drive(4'hD, 1'b1, 8'h5A, 2);
    pulse(4);
    check("addr one", 16'(addr2), 16'h1);
    drive(4'hE, 1'b1, 8'h5A, 3);
    drive(4'hF, 1'b1, 8'h5A, 2);
    pulse(3);
    check("three pulses", 16'(addr2), 16'h1);
    drive(4'h5, 1'b1, 8'h00, 2);
    drive(4'hD, 1'b1, 8'h00, 2);
    pulse(3);
    check("prescaler clear", 16'(addr2), 16'h0);
    pulse(1);
    drive(4'hC, 1'b1, 8'h00, 3);
    check("read loc 1", 16'({lk2.data_high_nibble, lk2.data_low_nibble}), 16'h5A);
    pulse(4);
    check("verify step", 16'(addr2), 16'h2);
    drive(4'hD, 1'b1, 8'h00, 2);
    drive(4'h5, 1'b1, 8'h00, 2);
    drive(4'hC, 1'b1, 8'h00, 3);
    check("read loc 0", 16'({lk2.data_high_nibble, lk2.data_low_nibble}), 16'h3C);
    // enable low: step pulses must not reach the counter
    drive(4'hD, 1'b1, 8'h00, 2);
    ce_i = 1'b0;
    pulse(4);
    check("ce freeze", 16'(addr2), 16'h0);
    ce_i = 1'b1;
    tick(2);
    check("ce held", 16'(addr2), 16'h0);
    for (int m = 0; m < 16; m++) begin
      drive(4'(m), 1'b1, 8'h00, 2);
      check("mode decode", 16'(op2), 16'(exp_op(4'(m))));
    end
    $display("pin level test ended");
    test_done();
  end
endmodule // prom_program_verify_port_bench

/* File: verilog/ppv_consts.svh */
// timing counts, field positions and mode codes for the program/verify port
`ifndef PPV_CONSTS_SVH
`define PPV_CONSTS_SVH
`define PPV_DEPTH 16384
`define PPV_ADDR_W 14
`define PPV_DATA_W 8
`define PPV_NIB_W 4
`define PPV_PRE_W 2
`define PPV_PULSES_PER_STEP 4
`define PPV_LO_MSB 3
`define PPV_HI_LSB 4
`define PPV_HI_MSB 7
`define PPV_MODE_CLEAR 4'h5
`define PPV_MODE_WRITE 4'hE
`define PPV_MODE_VERIFY 4'hC
`define PPV_MODE_INH_A 4'hD
`define PPV_MODE_INH_B 4'hF
`define PPV_CLK_MHZ 40
`define PPV_WRITE_US 1000
`define PPV_WRITE_CYC (`PPV_WRITE_US * `PPV_CLK_MHZ)
`define PPV_PHASE_CYC 4
`define PPV_FIFO_DEPTH 8
`endif

/* File: verilog/ppv_device.sv */
// device end: program memory array, address counter and mode decoder
// ****************************************************************
// Summary of operation
// RULE_01: 16384 byte locations, all reachable
// RULE_02: no address pins, counter stepped by clock
// RULE_03: programmer drives inverse step clock
// RULE_04: low nibble bits 3-0, high 7-4
// RULE_05: modes only with programming supply present
// RULE_06: mode pins decode clear, write, verify, inhibit
// RULE_07: programmer clears address before raising supply
// RULE_08: programmer passes inhibit between operations
// RULE_09: programmer holds write one millisecond
// RULE_10: programmer verifies, rewrites on mismatch
// RULE_11: extra write of X milliseconds after pass
// RULE_12: inhibit mode: four pulses advance one
// RULE_13: programmer repeats to end, then clears
// RULE_14: verify drives byte, advances every four pulses
// RULE_15: 14-bit counter, 2-bit prescaler, cleared together
// ****************************************************************
`timescale 1ns/1ps
`include "ppv_consts.svh"
module ppv_device
  import ppv_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // link to programmer
  ppv_link_if.device link,
  // user side status
  output logic [`PPV_ADDR_W-1:0] addr_o,
  output ppv_op_t op_o,
  output logic wrote_o
);
  // ****************************************************************
  // decode and storage
  // ****************************************************************
  logic [`PPV_DATA_W-1:0] mem [`PPV_DEPTH];
  logic [`PPV_ADDR_W-1:0] addr;
  logic [`PPV_PRE_W-1:0] pre;
  logic step_q;
  logic step_rise;
  ppv_op_t op;
  logic [3:0] pins;
  logic [`PPV_DATA_W-1:0] wr_byte;

  // pin order 0..3 maps to bit 0..3 of the mode code
  function automatic ppv_op_t decode(input logic ok, input logic [3:0] m);
    if (!ok) begin
      return PPV_OP_IDLE; // [RULE_05]
    end
    case (m) // [RULE_06]
      `PPV_MODE_CLEAR: return PPV_OP_CLEAR;
      `PPV_MODE_WRITE: return PPV_OP_WRITE;
      `PPV_MODE_VERIFY: return PPV_OP_VERIFY;
      `PPV_MODE_INH_A, `PPV_MODE_INH_B: return PPV_OP_INHIBIT;
      default: return PPV_OP_IDLE;
    endcase
  endfunction

  assign pins = link.mode_select_pins;
  assign op = decode(link.prog_supply_ok, pins);
  assign step_rise = link.step_clock_in && !step_q;
  // complement pin assumed correct; only the true pin is counted [RULE_03]
  assign wr_byte = {link.data_high_nibble, link.data_low_nibble}; // [RULE_04]

  // edge detect on the step clock pin
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      step_q <= 1'b0;
    end else if (ce_i) begin
      step_q <= link.step_clock_in;
    end
  end

  // address counter with prescaler, no external address [RULE_02]
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      addr <= '0;
      pre <= '0;
    end else if (ce_i) begin
      if (op == PPV_OP_CLEAR) begin
        addr <= '0; // [RULE_15]
        pre <= '0;
      end else if ((op == PPV_OP_INHIBIT || op == PPV_OP_VERIFY) && step_rise) begin
        pre <= pre + 1'b1;
        if (pre == 2'(`PPV_PULSES_PER_STEP - 1)) begin
          addr <= addr + 1'b1; // [RULE_12] [RULE_14]
        end
      end
    end
  end

  // array write; the 14-bit address counter wraps at the top so every index is valid [RULE_01]
  always_ff @(posedge clk_sys_i) begin
    if (ce_i && op == PPV_OP_WRITE) begin
      mem[addr] <= wr_byte;
    end
  end

  // ****************************************************************
  // pin drive and status
  // ****************************************************************
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      link.dev_oe <= 1'b0;
      link.lo_dev <= '0;
      link.hi_dev <= '0;
    end else if (ce_i) begin
      link.dev_oe <= (op == PPV_OP_VERIFY); // [RULE_14]
      link.lo_dev <= mem[addr][`PPV_LO_MSB:0]; // [RULE_04]
      link.hi_dev <= mem[addr][`PPV_HI_MSB:`PPV_HI_LSB];
    end
  end

  // status mirrors for the user side
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      addr_o <= '0;
      op_o <= PPV_OP_IDLE;
      wrote_o <= 1'b0;
    end else if (ce_i) begin
      addr_o <= addr;
      op_o <= op;
      wrote_o <= (op == PPV_OP_WRITE);
    end
  end
endmodule // ppv_device

/* File: verilog/ppv_fifo.sv */
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module ppv_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // full/empty taken straight from the occupancy count
  assign in_ready_o = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];
  assign push = ce_i && in_valid_i && in_ready_o;
  assign pop = ce_i && out_valid_o && out_ready_i;

  // storage writes, no reset needed on data
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // pointers and occupancy
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // ppv_fifo

/* File: verilog/ppv_host.sv */
// programmer end: write/verify/advance sequencer fed by a byte fifo
`timescale 1ns/1ps
`include "ppv_consts.svh"
module ppv_host
  import ppv_pkg::*;
#(
  parameter int WRITE_CYC = `PPV_WRITE_CYC,
  parameter int MAX_TRIES = 25
) (
  // clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // link to device
  ppv_link_if.host link,
  // user byte stream
  input wire logic start_i,
  input wire logic [`PPV_ADDR_W-1:0] last_addr_i,
  input wire logic byte_valid_i,
  output logic byte_ready_o,
  input wire logic [`PPV_DATA_W-1:0] byte_i,
  // status
  output logic busy_o,
  output logic done_o,
  output logic fail_o
);
  typedef enum logic [3:0] {
    H_IDLE, H_CLR, H_PWR, H_INH0, H_WAIT, H_WR, H_INH1, H_VER, H_PRE, H_INH2,
    H_STEP, H_END, H_OFF
  } ppv_hst_t;

  ppv_hst_t st;
  logic f_valid;
  logic f_pop;
  logic [`PPV_DATA_W-1:0] f_data;
  logic [31:0] tmr;
  logic [7:0] tries;
  logic extra;
  logic [3:0] pulses;
  logic [`PPV_ADDR_W-1:0] addr;
  logic [`PPV_DATA_W-1:0] rd_byte;

  // incoming bytes buffered; stalls the source only when all 8 fifo entries are full
  ppv_fifo #(.WIDTH(`PPV_DATA_W), .DEPTH(`PPV_FIFO_DEPTH)) u_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .in_valid_i(byte_valid_i),
    .in_ready_o(byte_ready_o),
    .in_data_i(byte_i),
    .out_valid_o(f_valid),
    .out_ready_i(f_pop),
    .out_data_o(f_data)
  );

  assign f_pop = ce_i && st == H_STEP && pulses == 4'(`PPV_PULSES_PER_STEP * 2);
  assign rd_byte = {link.data_high_nibble, link.data_low_nibble}; // [RULE_04]

  // sequencer
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st <= H_IDLE;
      tmr <= '0;
      tries <= '0;
      extra <= 1'b0;
      pulses <= '0;
      addr <= '0;
      link.mode_select_pins <= `PPV_MODE_INH_B;
      link.step_clock_in <= 1'b0;
      link.step_clock_complement <= 1'b1;
      link.prog_supply_ok <= 1'b0;
      link.lo_host <= '0;
      link.hi_host <= '0;
      link.host_oe <= 1'b0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      fail_o <= 1'b0;
    end else if (ce_i) begin
      done_o <= 1'b0;
      tmr <= tmr + 1;
      case (st)
        H_IDLE: begin
          if (start_i) begin
            busy_o <= 1'b1;
            fail_o <= 1'b0;
            addr <= '0;
            tmr <= '0;
            link.mode_select_pins <= `PPV_MODE_CLEAR; // [RULE_07]
            st <= H_CLR;
          end
        end
        H_CLR: begin
          link.prog_supply_ok <= 1'b1;
          tmr <= '0;
          st <= H_PWR;
        end
        H_PWR: begin
          if (tmr >= `PPV_PHASE_CYC) begin
            link.mode_select_pins <= `PPV_MODE_INH_B; // [RULE_08]
            tmr <= '0;
            st <= H_INH0;
          end
        end
        H_INH0: begin
          tries <= '0;
          extra <= 1'b0;
          st <= H_WAIT;
        end
        H_WAIT: begin
          if (f_valid) begin
            link.lo_host <= f_data[`PPV_LO_MSB:0];
            link.hi_host <= f_data[`PPV_HI_MSB:`PPV_HI_LSB];
            link.host_oe <= 1'b1;
            link.mode_select_pins <= `PPV_MODE_WRITE;
            tries <= tries + 1'b1;
            tmr <= '0;
            st <= H_WR;
          end
        end
        H_WR: begin
          // one ms per attempt, X ms for the final extra write [RULE_09] [RULE_11]
          if (tmr >= (extra ? WRITE_CYC * int'(tries) : WRITE_CYC) - 1) begin
            link.mode_select_pins <= `PPV_MODE_INH_B; // [RULE_08]
            tmr <= '0;
            st <= extra ? H_INH2 : H_INH1;
          end
        end
        H_INH1: begin
          link.host_oe <= 1'b0;
          link.mode_select_pins <= `PPV_MODE_VERIFY;
          tmr <= '0;
          st <= H_VER;
        end
        H_VER: begin
          if (tmr >= `PPV_PHASE_CYC) begin
            // every exit from verify passes through inhibit first [RULE_08]
            link.mode_select_pins <= `PPV_MODE_INH_B;
            if (rd_byte == f_data) begin
              extra <= 1'b1;
              st <= H_PRE;
            end else if (int'(tries) >= MAX_TRIES) begin
              fail_o <= 1'b1;
              st <= H_END;
            end else begin
              st <= H_WAIT; // tries kept so the extra write is X ms [RULE_10]
            end
          end
        end
        H_PRE: begin
          // drive only once the device has let go of the nibbles
          link.host_oe <= 1'b1;
          link.mode_select_pins <= `PPV_MODE_WRITE; // [RULE_11]
          tmr <= '0;
          st <= H_WR;
        end
        H_INH2: begin
          link.host_oe <= 1'b0;
          pulses <= '0;
          st <= H_STEP;
        end
        H_STEP: begin
          // four pulses, complement pin always inverse [RULE_12] [RULE_03]
          if (pulses < 4'(`PPV_PULSES_PER_STEP * 2)) begin
            link.step_clock_in <= !link.step_clock_in;
            link.step_clock_complement <= link.step_clock_in;
            pulses <= pulses + 1'b1;
          end else if (addr == last_addr_i) begin
            st <= H_END; // [RULE_13]
          end else begin
            addr <= addr + 1'b1;
            tries <= '0;
            extra <= 1'b0;
            st <= H_WAIT;
          end
        end
        H_END: begin
          // clear is selected while the supply is still up [RULE_13]
          link.mode_select_pins <= `PPV_MODE_CLEAR;
          st <= H_OFF;
        end
        H_OFF: begin
          link.prog_supply_ok <= 1'b0;
          busy_o <= 1'b0;
          done_o <= 1'b1;
          st <= H_IDLE;
        end
        default: st <= H_IDLE;
      endcase
    end
  end
endmodule // ppv_host

/* File: verilog/ppv_link_if.sv */
// pin-level link between the programmer and the device port
`timescale 1ns/1ps
interface ppv_link_if;
  logic [3:0] mode_select_pins;
  logic step_clock_in;
  logic step_clock_complement;
  logic prog_supply_ok;
  logic [3:0] lo_host;
  logic [3:0] hi_host;
  logic host_oe;
  logic [3:0] lo_dev;
  logic [3:0] hi_dev;
  logic dev_oe;
  wire [3:0] data_low_nibble = dev_oe ? lo_dev : (host_oe ? lo_host : 4'h0);
  wire [3:0] data_high_nibble = dev_oe ? hi_dev : (host_oe ? hi_host : 4'h0);
  modport device (
    input mode_select_pins, step_clock_in, step_clock_complement, prog_supply_ok,
    input data_low_nibble, data_high_nibble,
    output lo_dev, hi_dev, dev_oe
  );
  modport host (
    output mode_select_pins, step_clock_in, step_clock_complement, prog_supply_ok,
    output lo_host, hi_host, host_oe,
    input data_low_nibble, data_high_nibble
  );
endinterface

/* File: verilog/ppv_pkg.sv */
// types shared by both ends of the program/verify port
package ppv_pkg;
  typedef enum logic [2:0] {
    PPV_OP_IDLE,
    PPV_OP_CLEAR,
    PPV_OP_WRITE,
    PPV_OP_VERIFY,
    PPV_OP_INHIBIT
  } ppv_op_t;
endpackage
